// [atsc_pkg.sv]
// Constants for the asynchronous timer status and interrupt control block
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
// Summary of operation
// - Select bit picks I/O or crystal clock
// - Select change may corrupt timer registers
// - Counter write sets busy until loaded
// - Compare write sets busy until loaded
// - Control write sets busy until loaded
// - Counter reads live; others read temporaries
// - Compare request needs enable, global, flag
// - Overflow request needs enable, global, flag
// - Compare flag set on match, cleared
// - Overflow flag set on overflow, cleared
// - Pulse-width mode: overflow at bottom reversal
// - Sync mode holds prescaler reset bits
// - Sync mode off clears both reset bits
// - Prescaler reset bit self-clears; zero ignored
// - Reset bit reads zero on CPU clock
// - Async reset bit stays until completed
// - I/O offsets, data space plus 0x20
// - Status register at 0x30, resets zero
`default_nettype none
package atsc_pkg;
  // I/O offsets
  localparam logic [5:0] OFS_SPECIAL_FUNCTION_CTRL = 6'h20;
  localparam logic [5:0] OFS_ASYNC_TIMER_STATUS    = 6'h30;
  localparam logic [5:0] OFS_TIMER_COMPARE_VALUE   = 6'h31;
  localparam logic [5:0] OFS_TIMER_COUNT_VALUE     = 6'h32;
  localparam logic [5:0] OFS_TIMER_CONTROL_REG     = 6'h33;
  localparam logic [5:0] OFS_TIMER_IRQ_FLAGS       = 6'h36;
  localparam logic [5:0] OFS_TIMER_IRQ_MASK        = 6'h37;
  // Data-space distance of the I/O window
  localparam logic [7:0] DATA_SPACE_BASE           = 8'h20;
  localparam logic [7:0] IO_SPACE_LAST             = 8'h3F;
  // Status register fields
  localparam int BIT_ASYNC_CLOCK_SELECT    = 3;
  localparam int BIT_COUNTER_UPDATE_BUSY   = 2;
  localparam int BIT_COMPARE_UPDATE_BUSY   = 1;
  localparam int BIT_CONTROL_UPDATE_BUSY   = 0;
  // Mask and flag fields
  localparam int BIT_COMPARE               = 1;
  localparam int BIT_OVERFLOW              = 0;
  // Special function fields
  localparam int BIT_SYNC_MODE             = 7;
  localparam int BIT_PRESCALER_RESET_SHARED = 2;
  localparam int BIT_PRESCALER_RESET_A     = 1;
  // Control register: phase correct pulse-width mode bits
  localparam int BIT_WGM0                  = 6;
  localparam int BIT_WGM1                  = 3;
  // Reset values
  localparam logic [7:0] RST_REG           = 8'h00;
endpackage
`default_nettype wire

// [atsc_top.sv]
// Status, clock select, update busy, interrupt flag and prescaler reset logic
`timescale 1ns/1ps
`default_nettype none
module atsc_top #(
  parameter int DW = 8                        // Register data width
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // CPU register port
  input  wire logic [7:0]    reg_addr,        // I/O or data-space address
  input  wire logic          reg_data_space,  // High: address is data space
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [DW-1:0] reg_wdata,
  output logic [DW-1:0]      reg_rdata,       // Valid the cycle after reg_rd
  // CPU interrupt side
  input  wire logic          cpu_global_ie,   // Global enable bit of cpu_status_reg
  input  wire logic          cmp_vector_taken,
  input  wire logic          ovf_vector_taken,
  output logic               cmp_irq_req,
  output logic               ovf_irq_req,
  // Counter core side
  input  wire logic          crystal_osc_input,
  input  wire logic [DW-1:0] core_count,      // Live counter value
  input  wire logic          core_match,      // Compare match pulse
  input  wire logic          core_overflow,   // Overflow pulse (MAX)
  input  wire logic          core_bottom_rev, // Direction reversal at 0x00
  output logic               async_clock_select,
  output logic               core_count_load,  // Pulse: load count
  output logic [DW-1:0]      core_count_value,
  output logic [DW-1:0]      core_compare_value,
  output logic [DW-1:0]      core_control_value,
  output logic               prescaler_rst_a,
  output logic               prescaler_rst_shared
);

  //----------------------------------------------------------------------------
  // Reset synchroniser
  //----------------------------------------------------------------------------
  logic rst_meta_q;                            // First stage, read by second only
  logic rst_sync_n_q;                          // Design-wide reset

  // Release through two flops so all state leaves reset on one edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q   <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_q   <= 1'b1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  //----------------------------------------------------------------------------
  // Address decode
  //----------------------------------------------------------------------------
  logic [7:0] io_ofs;                          // Address folded to I/O offset
  logic       io_ok;                           // Address inside the I/O window
  logic       wr_cnt, wr_cmp, wr_ctl, wr_sts, wr_flg, wr_msk, wr_sfc;

  // Data-space accesses sit 0x20 above the I/O offsets
  always_comb begin
    io_ofs = reg_data_space ? 8'(reg_addr - atsc_pkg::DATA_SPACE_BASE) : reg_addr;
    io_ok  = (io_ofs <= atsc_pkg::IO_SPACE_LAST) &&
             (!reg_data_space || reg_addr >= atsc_pkg::DATA_SPACE_BASE);
  end

  assign wr_cnt = reg_wr && io_ok && io_ofs[5:0] == atsc_pkg::OFS_TIMER_COUNT_VALUE;
  assign wr_cmp = reg_wr && io_ok && io_ofs[5:0] == atsc_pkg::OFS_TIMER_COMPARE_VALUE;
  assign wr_ctl = reg_wr && io_ok && io_ofs[5:0] == atsc_pkg::OFS_TIMER_CONTROL_REG;
  assign wr_sts = reg_wr && io_ok && io_ofs[5:0] == atsc_pkg::OFS_ASYNC_TIMER_STATUS;
  assign wr_flg = reg_wr && io_ok && io_ofs[5:0] == atsc_pkg::OFS_TIMER_IRQ_FLAGS;
  assign wr_msk = reg_wr && io_ok && io_ofs[5:0] == atsc_pkg::OFS_TIMER_IRQ_MASK;
  assign wr_sfc = reg_wr && io_ok && io_ofs[5:0] == atsc_pkg::OFS_SPECIAL_FUNCTION_CTRL;

  //----------------------------------------------------------------------------
  // Crystal tick
  //----------------------------------------------------------------------------
  logic [2:0] xtal_q;                          // Two sync stages plus edge stage
  logic       xtal_tick;                       // One-cycle enable per rising crystal edge

  // The crystal is sampled as a plain input; its rising edge is the
  // moment the asynchronous side accepts staged values
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      xtal_q <= 3'h0;
    end else begin
      xtal_q <= {xtal_q[1:0], crystal_osc_input};
    end
  end

  // Edge detect uses stages two and three only, never the first
  assign xtal_tick = xtal_q[1] && !xtal_q[2];

  //----------------------------------------------------------------------------
  // Clock select and staged registers
  //----------------------------------------------------------------------------
  logic          as_q;                         // Clock select bit
  logic [DW-1:0] tmp_cnt_q, tmp_cmp_q, tmp_ctl_q; // Temporary storage
  logic [2:0]    busy_q;                       // {counter, compare, control}
  logic [2:0]    wr_vec;

  assign wr_vec = {wr_cnt, wr_cmp, wr_ctl};

  // Select bit; a change may leave timer contents undefined, software
  // must reload them, so no attempt is made to preserve them
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      as_q <= 1'b0;
    end else if (wr_sts) begin
      as_q <= reg_wdata[atsc_pkg::BIT_ASYNC_CLOCK_SELECT];
    end
  end

  // Temporaries capture every CPU write
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      tmp_cnt_q <= atsc_pkg::RST_REG;
      tmp_cmp_q <= atsc_pkg::RST_REG;
      tmp_ctl_q <= atsc_pkg::RST_REG;
    end else begin
      if (wr_cnt) begin
        tmp_cnt_q <= reg_wdata;
      end
      if (wr_cmp) begin
        tmp_cmp_q <= reg_wdata;
      end
      if (wr_ctl) begin
        tmp_ctl_q <= reg_wdata;
      end
    end
  end

  // Busy flags: set on an async write, cleared at the crystal tick that
  // moves the value; a write in the tick cycle keeps the flag set
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_busy
      always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
          busy_q[gi] <= 1'b0;
        end else if (wr_vec[gi] && as_q) begin
          busy_q[gi] <= 1'b1;
        end else if (xtal_tick || !as_q) begin
          busy_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Transfer to the core: at once on the I/O clock, at the tick when async.
  // A write while busy overwrites the staged value; software is expected
  // to poll the busy bit first
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      core_count_load    <= 1'b0;
      core_count_value   <= atsc_pkg::RST_REG;
      core_compare_value <= atsc_pkg::RST_REG;
      core_control_value <= atsc_pkg::RST_REG;
    end else begin
      core_count_load <= 1'b0;
      if (!as_q) begin
        core_count_load <= wr_cnt;
        if (wr_cnt) begin
          core_count_value <= reg_wdata;
        end
        if (wr_cmp) begin
          core_compare_value <= reg_wdata;
        end
        if (wr_ctl) begin
          core_control_value <= reg_wdata;
        end
      end else if (xtal_tick) begin
        core_count_load <= busy_q[2];
        if (busy_q[2]) begin
          core_count_value <= tmp_cnt_q;
        end
        if (busy_q[1]) begin
          core_compare_value <= tmp_cmp_q;
        end
        if (busy_q[0]) begin
          core_control_value <= tmp_ctl_q;
        end
      end
    end
  end

  assign async_clock_select = as_q;

  //----------------------------------------------------------------------------
  // Interrupt mask and flags
  //----------------------------------------------------------------------------
  logic [1:0] msk_q, flg_q;                    // {compare, overflow}
  logic       pwm_phase;                       // Phase correct mode
  logic       ovf_event;

  assign pwm_phase = core_control_value[atsc_pkg::BIT_WGM0] &&
                     !core_control_value[atsc_pkg::BIT_WGM1];
  assign ovf_event = pwm_phase ? core_bottom_rev : core_overflow;

  // Mask register
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      msk_q <= 2'h0;
    end else if (wr_msk) begin
      msk_q <= reg_wdata[1:0];
    end
  end

  // Flags: set beats the write-one clear and the vector clear
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      flg_q <= 2'h0;
    end else begin
      if (core_match) begin
        flg_q[atsc_pkg::BIT_COMPARE] <= 1'b1;
      end else if (cmp_vector_taken || (wr_flg && reg_wdata[atsc_pkg::BIT_COMPARE])) begin
        flg_q[atsc_pkg::BIT_COMPARE] <= 1'b0;
      end
      if (ovf_event) begin
        flg_q[atsc_pkg::BIT_OVERFLOW] <= 1'b1;
      end else if (ovf_vector_taken || (wr_flg && reg_wdata[atsc_pkg::BIT_OVERFLOW])) begin
        flg_q[atsc_pkg::BIT_OVERFLOW] <= 1'b0;
      end
    end
  end

  // Requests, one cycle behind the flag
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      cmp_irq_req <= 1'b0;
      ovf_irq_req <= 1'b0;
    end else begin
      cmp_irq_req <= cpu_global_ie && msk_q[atsc_pkg::BIT_COMPARE] && flg_q[atsc_pkg::BIT_COMPARE];
      ovf_irq_req <= cpu_global_ie && msk_q[atsc_pkg::BIT_OVERFLOW] && flg_q[atsc_pkg::BIT_OVERFLOW];
    end
  end

  //----------------------------------------------------------------------------
  // Prescaler reset and synchronisation mode
  //----------------------------------------------------------------------------
  logic tsm_q;                                 // Synchronisation mode bit
  logic psr_a_q, psr_s_q;                      // Reset bits as stored

  // Sync mode bit
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      tsm_q <= 1'b0;
    end else if (wr_sfc) begin
      tsm_q <= reg_wdata[atsc_pkg::BIT_SYNC_MODE];
    end
  end

  // Reset bit for this timer: set by a written one, held in sync mode,
  // otherwise cleared once the reset has taken place (next cycle on the
  // I/O clock, at the next crystal tick when asynchronous)
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      psr_a_q <= 1'b0;
    end else if (wr_sfc && reg_wdata[atsc_pkg::BIT_PRESCALER_RESET_A]) begin
      psr_a_q <= 1'b1;
    end else if (wr_sfc && !reg_wdata[atsc_pkg::BIT_SYNC_MODE]) begin
      psr_a_q <= 1'b0;
    end else if (!tsm_q && (!as_q || xtal_tick)) begin
      psr_a_q <= 1'b0;
    end
  end

  // Shared reset bit runs on the I/O clock only
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      psr_s_q <= 1'b0;
    end else if (wr_sfc && reg_wdata[atsc_pkg::BIT_PRESCALER_RESET_SHARED]) begin
      psr_s_q <= 1'b1;
    end else if (wr_sfc && !reg_wdata[atsc_pkg::BIT_SYNC_MODE]) begin
      psr_s_q <= 1'b0;
    end else if (!tsm_q) begin
      psr_s_q <= 1'b0;
    end
  end

  assign prescaler_rst_a      = psr_a_q;
  assign prescaler_rst_shared = psr_s_q;

  //----------------------------------------------------------------------------
  // Read data
  //----------------------------------------------------------------------------
  // Registered read mux; unmapped offsets return zero
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      reg_rdata <= atsc_pkg::RST_REG;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (io_ok) begin
        case (io_ofs[5:0])
          atsc_pkg::OFS_TIMER_COUNT_VALUE:   reg_rdata <= core_count;
          atsc_pkg::OFS_TIMER_COMPARE_VALUE: reg_rdata <= tmp_cmp_q;
          atsc_pkg::OFS_TIMER_CONTROL_REG:   reg_rdata <= tmp_ctl_q;
          atsc_pkg::OFS_ASYNC_TIMER_STATUS: begin
            reg_rdata <= {4'h0, as_q, busy_q};
          end
          atsc_pkg::OFS_TIMER_IRQ_MASK:      reg_rdata <= {6'h00, msk_q};
          atsc_pkg::OFS_TIMER_IRQ_FLAGS:     reg_rdata <= {6'h00, flg_q};
          atsc_pkg::OFS_SPECIAL_FUNCTION_CTRL: begin
            reg_rdata <= {tsm_q, 4'h0, psr_s_q, psr_a_q && as_q, 1'b0};
          end
          default:                           reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [atsc_top_props.sv]
// Concurrent checks on the ports of the timer status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module atsc_top_props #(
  parameter int DW = 8              // Register data width
) (
  // Clock and reset
  input wire logic          clk_sys,
  input wire logic          rst_n,
  // CPU register port
  input wire logic [7:0]    reg_addr,
  input wire logic          reg_data_space,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic [DW-1:0] reg_rdata,
  // CPU interrupt side
  input wire logic          cpu_global_ie,
  input wire logic          cmp_vector_taken,
  input wire logic          ovf_vector_taken,
  input wire logic          cmp_irq_req,
  input wire logic          ovf_irq_req,
  // Counter core side
  input wire logic          crystal_osc_input,
  input wire logic [DW-1:0] core_count,
  input wire logic          core_match,
  input wire logic          core_overflow,
  input wire logic          core_bottom_rev,
  input wire logic          async_clock_select,
  input wire logic          core_count_load,
  input wire logic [DW-1:0] core_count_value,
  input wire logic [DW-1:0] core_compare_value,
  input wire logic [DW-1:0] core_control_value,
  input wire logic          prescaler_rst_a,
  input wire logic          prescaler_rst_shared
);
  // ----------------------------------------------------------------
  // Decode helpers, I/O space only except where noted
  // ----------------------------------------------------------------
  logic wr_sfc;                     // Write to special_function_ctrl
  logic wr_stat;                    // Write to async_timer_status, either space
  assign wr_sfc  = reg_wr && !reg_data_space && (reg_addr == 8'h20);
  assign wr_stat = reg_wr && (reg_data_space ? (reg_addr == 8'h50) : (reg_addr == 8'h30));
  // Single domain, so one clock and one disable for all
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_cmp_gate;
    cmp_irq_req |-> $past(cpu_global_ie);
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("compare request without global enable");
  property p_ovf_gate;
    !cpu_global_ie |=> !ovf_irq_req;
  endproperty
  a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request without global enable");
  property p_sel_write;
    $changed(async_clock_select) |-> $past(wr_stat);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("clock select moved without a write");
  property p_cmp_sync;
    (reg_wr && !reg_data_space && reg_addr == 8'h31 && !async_clock_select) |=> core_compare_value == $past(reg_wdata);
  endproperty
  a_cmp_sync: assert property (p_cmp_sync) else $error("compare value not passed on in sync mode");
  property p_cnt_sync;
    (reg_wr && !reg_data_space && reg_addr == 8'h32 && !async_clock_select) |=> core_count_value == $past(reg_wdata);
  endproperty
  a_cnt_sync: assert property (p_cnt_sync) else $error("count value not passed on in sync mode");
  property p_tsm_off;
    (wr_sfc && !reg_wdata[7] && !reg_wdata[2] && !reg_wdata[1]) |=> !prescaler_rst_a && !prescaler_rst_shared;
  endproperty
  a_tsm_off: assert property (p_tsm_off) else $error("prescaler resets not cleared");
  property p_psr_pulse;
    (wr_sfc && !reg_wdata[7] && reg_wdata[1] && !async_clock_select) |=> prescaler_rst_a ##1 !prescaler_rst_a;
  endproperty
  a_psr_pulse: assert property (p_psr_pulse) else $error("prescaler reset did not self-clear");
  property p_tsm_hold;
    (wr_sfc && reg_wdata[7] && reg_wdata[1]) |=> prescaler_rst_a;
  endproperty
  a_tsm_hold: assert property (p_tsm_hold) else $error("prescaler reset not held");
  property p_status_rd;
    (reg_rd && !reg_data_space && reg_addr == 8'h30) |=> reg_rdata[7:3] == {4'h0, $past(async_clock_select)};
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");
  property p_unmapped;
    (reg_rd && !reg_data_space && reg_addr == 8'h10) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cnt_rd;
    (reg_rd && reg_data_space && reg_addr == 8'h52) |=> reg_rdata == $past(core_count);
  endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("counter read not live");
  property p_psr_zero;
    (reg_rd && !reg_data_space && reg_addr == 8'h20 && !async_clock_select) |=> !reg_rdata[1];
  endproperty
  a_psr_zero: assert property (p_psr_zero) else $error("prescaler reset bit read one");
  // Main scenarios reached
  c_cmp_req: cover property (cmp_irq_req);
  c_load:    cover property (core_count_load);
  c_psr:     cover property (prescaler_rst_a);
endmodule
bind atsc_top atsc_top_props #(.DW(DW)) u_atsc_top_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_data_space(reg_data_space),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .cpu_global_ie(cpu_global_ie), .cmp_vector_taken(cmp_vector_taken), .ovf_vector_taken(ovf_vector_taken),
  .cmp_irq_req(cmp_irq_req), .ovf_irq_req(ovf_irq_req), .crystal_osc_input(crystal_osc_input),
  .core_count(core_count), .core_match(core_match), .core_overflow(core_overflow),
  .core_bottom_rev(core_bottom_rev), .async_clock_select(async_clock_select), .core_count_load(core_count_load),
  .core_count_value(core_count_value), .core_compare_value(core_compare_value),
  .core_control_value(core_control_value), .prescaler_rst_a(prescaler_rst_a),
  .prescaler_rst_shared(prescaler_rst_shared));
`default_nettype wire

// [atsc_top_tb.sv]
// Self-checking bench for the timer status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module atsc_top_tb;
  // ----------------------------------------------------------------
  // Signals; every input has a value at time zero
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0, rst_n = 1'b0, reg_data_space = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, core_count = 8'h00;
  logic        cpu_global_ie = 1'b0, cmp_vector_taken = 1'b0, ovf_vector_taken = 1'b0, crystal_osc_input = 1'b0;
  logic        core_match = 1'b0, core_overflow = 1'b0, core_bottom_rev = 1'b0;
  logic [7:0]  reg_rdata, core_count_value, core_compare_value, core_control_value;
  logic        cmp_irq_req, ovf_irq_req, async_clock_select, core_count_load, prescaler_rst_a, prescaler_rst_shared;
  logic [15:0] exp_q[$];                 // Read notes: mask in upper byte
  logic [15:0] note;                     // Oldest note being compared
  logic        rd_seen = 1'b0;           // A read was taken at the last edge
  logic [31:0] seed = 32'hFCC049F2;      // Random state
  logic [7:0]  v_cnt, v_cmp, v_ctl;      // Random register values
  logic [7:0]  ofs[8] = '{8'h20, 8'h30, 8'h31, 8'h32, 8'h33, 8'h36, 8'h37, 8'h10};
  int          num_errors = 0, num_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  atsc_top u_atsc_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_data_space(reg_data_space), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cpu_global_ie(cpu_global_ie),
    .cmp_vector_taken(cmp_vector_taken), .ovf_vector_taken(ovf_vector_taken), .cmp_irq_req(cmp_irq_req),
    .ovf_irq_req(ovf_irq_req), .crystal_osc_input(crystal_osc_input), .core_count(core_count),
    .core_match(core_match), .core_overflow(core_overflow), .core_bottom_rev(core_bottom_rev),
    .async_clock_select(async_clock_select), .core_count_load(core_count_load),
    .core_count_value(core_count_value), .core_compare_value(core_compare_value),
    .core_control_value(core_control_value), .prescaler_rst_a(prescaler_rst_a),
    .prescaler_rst_shared(prescaler_rst_shared));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    num_checks++;
    if (seen !== expd) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // One bus cycle; a read notes its expected byte and mask
  task automatic bus(input logic wr, input logic ds, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(negedge clk_sys);
    reg_addr = a;
    reg_data_space = ds;
    reg_wdata = wr ? d : 8'hA5;
    reg_wr = wr;
    reg_rd = !wr;
    if (!wr) exp_q.push_back({m, d});
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  // Core pulse order: match, overflow, bottom reversal, compare vector, overflow vector
  task automatic pulse(input logic [4:0] p);
    @(negedge clk_sys);
    {core_match, core_overflow, core_bottom_rev, cmp_vector_taken, ovf_vector_taken} = p;
    @(negedge clk_sys);
    {core_match, core_overflow, core_bottom_rev, cmp_vector_taken, ovf_vector_taken} = 5'h00;
    cyc(2);
  endtask
  // Crystal stands still between ticks
  task automatic tick;
    crystal_osc_input = 1'b1;
    cyc(4);
    crystal_osc_input = 1'b0;
    cyc(3);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Read monitor: takes the oldest note once data has settled
  // ----------------------------------------------------------------
  always @(posedge clk_sys) rd_seen <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_seen) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFF00;
      check(reg_rdata & note[15:8], note[7:0] & note[15:8]);
    end
  end
  // Hang guard, far beyond the 160 or so cycles needed
  initial begin
    #1000000;
    num_errors++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(20);
    rst_n = 1'b1;
    cyc(3);
    foreach (ofs[i]) bus(1'b0, 1'b0, ofs[i], 8'h00, 8'hFF);
    bus(1'b0, 1'b1, 8'h10, 8'h00, 8'hFF);
    // Sync mode: writes reach the core at once, compare and control reads give temporaries, counter reads live
    seed = xs(seed);
    v_cmp = seed[7:0];
    seed = xs(seed);
    v_ctl = seed[7:0] & 8'hB7;           // Keep pulse-width mode off
    seed = xs(seed);
    core_count = seed[7:0];
    bus(1'b1, 1'b0, 8'h31, v_cmp, 8'h00);
    bus(1'b1, 1'b1, 8'h53, v_ctl, 8'h00);
    bus(1'b1, 1'b0, 8'h32, v_cmp, 8'h00);
    check({7'h00, core_count_load}, 8'h01);
    check(core_count_value, v_cmp);
    bus(1'b0, 1'b1, 8'h51, v_cmp, 8'hFF);
    bus(1'b0, 1'b0, 8'h33, v_ctl, 8'hFF);
    bus(1'b0, 1'b1, 8'h52, core_count, 8'hFF);
    check(core_compare_value, v_cmp);
    check(core_control_value, v_ctl);
    // Interrupt gating, vector clear and write-one clear
    cpu_global_ie = 1'b1;
    bus(1'b1, 1'b0, 8'h37, 8'h03, 8'h00);
    bus(1'b0, 1'b0, 8'h37, 8'h03, 8'h03);
    pulse(5'h10);
    check({7'h00, cmp_irq_req}, 8'h01);
    bus(1'b0, 1'b0, 8'h36, 8'h02, 8'h03);
    cpu_global_ie = 1'b0;
    cyc(2);
    check({7'h00, cmp_irq_req}, 8'h00);
    cpu_global_ie = 1'b1;
    pulse(5'h02);
    check({7'h00, cmp_irq_req}, 8'h00);
    pulse(5'h08);
    check({7'h00, ovf_irq_req}, 8'h01);
    bus(1'b1, 1'b1, 8'h56, 8'h01, 8'h00);
    cyc(2);
    check({7'h00, ovf_irq_req}, 8'h00);
    bus(1'b1, 1'b0, 8'h37, 8'h00, 8'h00);
    pulse(5'h08);
    check({7'h00, ovf_irq_req}, 8'h00);
    pulse(5'h01);
    bus(1'b0, 1'b0, 8'h36, 8'h00, 8'h03);
    // Pulse-width mode: overflow flag follows the bottom reversal only
    bus(1'b1, 1'b0, 8'h33, 8'h40, 8'h00);
    pulse(5'h08);
    bus(1'b0, 1'b0, 8'h36, 8'h00, 8'h01);
    pulse(5'h04);
    bus(1'b0, 1'b0, 8'h36, 8'h01, 8'h01);
    bus(1'b1, 1'b0, 8'h36, 8'h01, 8'h00);
    // Crystal clocking: busy flags until the crystal tick
    bus(1'b1, 1'b0, 8'h30, 8'h08, 8'h00);
    check({7'h00, async_clock_select}, 8'h01);
    seed = xs(seed);
    {v_cnt, v_cmp, v_ctl} = {seed[23:0] & 24'hFFFFB7};
    bus(1'b1, 1'b0, 8'h32, v_cnt, 8'h00);
    bus(1'b0, 1'b0, 8'h30, 8'h0C, 8'hFF);
    bus(1'b1, 1'b0, 8'h31, v_cmp, 8'h00);
    bus(1'b0, 1'b0, 8'h30, 8'h0E, 8'hFF);
    bus(1'b1, 1'b0, 8'h33, v_ctl, 8'h00);
    bus(1'b0, 1'b0, 8'h30, 8'h0F, 8'hFF);
    bus(1'b0, 1'b0, 8'h31, v_cmp, 8'hFF);
    tick();
    bus(1'b0, 1'b0, 8'h30, 8'h08, 8'hFF);
    check(core_count_value, v_cnt);
    check(core_compare_value, v_cmp);
    check(core_control_value, v_ctl);
    // Synchronization mode holds both prescaler resets
    bus(1'b1, 1'b0, 8'h20, 8'h86, 8'h00);
    tick();
    check({6'h00, prescaler_rst_shared, prescaler_rst_a}, 8'h03);
    bus(1'b1, 1'b0, 8'h20, 8'h00, 8'h00);
    check({6'h00, prescaler_rst_shared, prescaler_rst_a}, 8'h00);
    // Back on the CPU clock: reset bit reads zero, written zero does nothing
    bus(1'b1, 1'b0, 8'h30, 8'h00, 8'h00);
    bus(1'b1, 1'b0, 8'h20, 8'h82, 8'h00);
    bus(1'b1, 1'b0, 8'h20, 8'h80, 8'h00);
    check({7'h00, prescaler_rst_a}, 8'h01);
    bus(1'b0, 1'b0, 8'h20, 8'h00, 8'h02);
    bus(1'b1, 1'b0, 8'h20, 8'h00, 8'h00);
    check({7'h00, prescaler_rst_a}, 8'h00);
    bus(1'b1, 1'b0, 8'h20, 8'h02, 8'h00);
    check({7'h00, prescaler_rst_a}, 8'h01);
    cyc(1);
    check({7'h00, prescaler_rst_a}, 8'h00);
    cyc(3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
